//--- design/data_space_access_unit.sv
/*
 * Data-space access unit: decodes byte effective addresses into special
 * register and RAM space, steers byte lanes, serves X and Y read paths,
 * extends addresses with page registers and flags misaligned accesses.
 * Assumes requests are single-cycle strobes synchronous to core_clk and
 * that special registers live outside, reached through the sfr port.
 */
`timescale 1ns/100ps
module data_space_access_unit #(
    parameter int RAM_WORDS = 24576
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // X read request
    input wire logic x_rd_req,
    input wire logic x_rd_byte,
    input wire logic [1:0] x_rd_src,
    input wire logic [1:0] x_rd_mod,
    input wire logic [15:0] x_rd_direct,
    input wire logic [15:0] x_rd_pointer,
    // Y read request, multiply-accumulate class only
    input wire logic y_rd_req,
    input wire logic multiply_accumulate_class,
    input wire logic [1:0] y_rd_mod,
    input wire logic [15:0] y_rd_pointer,
    // Write request
    input wire logic wr_req,
    input wire logic wr_byte,
    input wire logic [1:0] wr_src,
    input wire logic [1:0] wr_mod,
    input wire logic [15:0] wr_direct,
    input wire logic [15:0] wr_pointer,
    input wire logic [15:0] wr_data,
    // Addressing modes
    input wire logic modulo_en,
    input wire logic [15:0] mod_start,
    input wire logic [15:0] mod_end,
    input wire logic bitrev_en,
    input wire logic [15:0] bitrev_pivot,
    // Page registers
    input wire logic read_page_we,
    input wire logic write_page_we,
    input wire logic [7:0] page_wdata,
    // Register result formatting
    input wire logic [1:0] reg_op,
    input wire logic [15:0] reg_old,
    input wire logic [15:0] reg_src,
    // Special register port
    input wire logic [15:0] sfr_rdata,
    input wire logic sfr_hit,
    output logic [15:0] sfr_addr,
    output logic sfr_rd,
    output logic sfr_wr,
    output logic [1:0] sfr_byte_wr,
    output logic [15:0] sfr_wdata,
    // Results
    output logic [15:0] x_rd_data,
    output logic [15:0] y_rd_data,
    output logic rd_valid,
    output logic [15:0] x_rd_pointer_next,
    output logic [15:0] y_rd_pointer_next,
    output logic [15:0] wr_pointer_next,
    output logic [23:0] rd_ext_addr,
    output logic [23:0] wr_ext_addr,
    output logic [7:0] read_page_register,
    output logic [7:0] write_page_register,
    output logic [15:0] reg_result,
    output logic address_error_trap
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    // Array depth must fit the 48 KB RAM window
    if (RAM_WORDS < 1 || RAM_WORDS > 24576) begin : g_bad_depth
        $error("RAM_WORDS must lie in 1..24576");
    end

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [7:0] rd_page;      // Read page
        logic [7:0] wr_page;      // Write page
        logic [15:0] x_data;      // X read result
        logic [15:0] y_data;      // Y read result
        logic valid;              // Read result ready
        logic x_sfr;              // X read came from special space
        logic x_ram;              // X read came from RAM
        logic x_byte;             // X read was byte
        logic x_hi;               // X byte lane select
        logic trap;               // Address error pending
    } state_s;

    state_s state_reg;
    state_s state_next;

    // Two byte-wide arrays share one word index
    logic [7:0] ram_low [RAM_WORDS];   // Low byte array
    logic [7:0] ram_high [RAM_WORDS];  // High byte array
    logic [15:0] x_ram_word_reg;       // Registered X RAM word
    logic [15:0] y_ram_word_reg;       // Registered Y RAM word

    logic [15:0] x_ea;
    logic [15:0] y_ea;
    logic [15:0] w_ea;
    logic x_in_sfr;
    logic x_in_ram;
    logic y_in_ram;
    logic w_in_sfr;
    logic w_in_ram;
    logic x_misalign;
    logic y_misalign;
    logic w_misalign;
    logic w_commit;
    logic [1:0] w_lanes;
    logic [14:0] x_word;
    logic [14:0] y_word;
    logic [14:0] w_word;
    logic [15:0] x_word_data;

    // Lane strobes are derived per request; they are never registered

    // ****************************************************************
    // Address units: separate read and write units, X and Y
    // ****************************************************************
    address_generation_unit #(.ALLOW_BIT_REVERSE(1'b0)) u_x_read (
        .src_sel(x_rd_src),
        .mod_sel(x_rd_mod),
        .byte_op(x_rd_byte),
        .direct_addr(x_rd_direct),
        .pointer_register(x_rd_pointer),
        .modulo_en(modulo_en),
        .mod_start(mod_start),
        .mod_end(mod_end),
        .bitrev_en(1'b0),
        .bitrev_pivot(16'h0000),
        .effective_address(x_ea),
        .pointer_next(x_rd_pointer_next)
    );

    address_generation_unit #(.ALLOW_BIT_REVERSE(1'b0)) u_y_read (
        .src_sel(data_space_pkg::SRC_POINTER),
        .mod_sel(y_rd_mod),
        .byte_op(1'b0),
        .direct_addr(16'h0000),
        .pointer_register(y_rd_pointer),
        .modulo_en(modulo_en),
        .mod_start(mod_start),
        .mod_end(mod_end),
        .bitrev_en(1'b0),
        .bitrev_pivot(16'h0000),
        .effective_address(y_ea),
        .pointer_next(y_rd_pointer_next)
    );

    address_generation_unit #(.ALLOW_BIT_REVERSE(1'b1)) u_x_write (
        .src_sel(wr_src),
        .mod_sel(wr_mod),
        .byte_op(wr_byte),
        .direct_addr(wr_direct),
        .pointer_register(wr_pointer),
        .modulo_en(modulo_en),
        .mod_start(mod_start),
        .mod_end(mod_end),
        .bitrev_en(bitrev_en),
        .bitrev_pivot(bitrev_pivot),
        .effective_address(w_ea),
        .pointer_next(wr_pointer_next)
    );

    // ****************************************************************
    // Decode and alignment
    // ****************************************************************
    always_comb begin
        x_in_sfr = (x_ea <= data_space_pkg::SFR_LAST);
        x_in_ram = (x_ea >= data_space_pkg::RAM_BASE) && (x_ea <= data_space_pkg::RAM_LAST);
        y_in_ram = (y_ea >= data_space_pkg::Y_BASE_DEF) && (y_ea <= data_space_pkg::RAM_LAST);
        w_in_sfr = (w_ea <= data_space_pkg::SFR_LAST);
        w_in_ram = (w_ea >= data_space_pkg::RAM_BASE) && (w_ea <= data_space_pkg::RAM_LAST);
        x_misalign = x_rd_req && !x_rd_byte && x_ea[0];
        y_misalign = y_rd_req && multiply_accumulate_class && y_ea[0];
        w_misalign = wr_req && !wr_byte && w_ea[0];
        w_commit = wr_req && !w_misalign && w_in_ram;
        // Shared word decode, byte lane strobes
        w_lanes = wr_byte ? {w_ea[0], !w_ea[0]} : 2'b11;
        x_word = 15'((x_ea - data_space_pkg::RAM_BASE) >> 1);
        y_word = 15'((y_ea - data_space_pkg::RAM_BASE) >> 1);
        w_word = 15'((w_ea - data_space_pkg::RAM_BASE) >> 1);
    end

    // Special register side: address and strobes pass straight out
    assign sfr_addr = {w_in_sfr && wr_req ? w_ea[15:1] : x_ea[15:1], 1'b0};
    assign sfr_rd = x_rd_req && x_in_sfr && !x_misalign;
    assign sfr_wr = wr_req && w_in_sfr && !w_misalign;
    assign sfr_byte_wr = sfr_wr ? w_lanes : 2'b00;
    assign sfr_wdata = wr_byte ? {wr_data[7:0], wr_data[7:0]} : wr_data;

    // ****************************************************************
    // RAM arrays: two byte lanes, one shared word index
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (w_commit && w_lanes[0] && 32'(w_word) < RAM_WORDS) begin
            ram_low[w_word] <= wr_data[7:0];
        end
        if (w_commit && w_lanes[1] && 32'(w_word) < RAM_WORDS) begin
            ram_high[w_word] <= wr_byte ? wr_data[7:0] : wr_data[15:8];
        end
        if (32'(x_word) < RAM_WORDS) begin
            x_ram_word_reg <= {ram_high[x_word], ram_low[x_word]};
        end else begin
            x_ram_word_reg <= 16'h0000;
        end
        if (32'(y_word) < RAM_WORDS) begin
            y_ram_word_reg <= {ram_high[y_word], ram_low[y_word]};
        end else begin
            y_ram_word_reg <= 16'h0000;
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        state_next = state_reg;
        state_next.valid = x_rd_req || y_rd_req;
        state_next.x_sfr = x_in_sfr && sfr_hit && !x_misalign;
        state_next.x_ram = x_in_ram && !x_misalign;
        state_next.x_byte = x_rd_byte;
        state_next.x_hi = x_ea[0];
        state_next.x_data = x_in_sfr && sfr_hit ? sfr_rdata : 16'h0000;
        state_next.trap = x_misalign || y_misalign || w_misalign;
        if (read_page_we) begin
            state_next.rd_page = page_wdata;
        end
        if (write_page_we) begin
            state_next.wr_page = page_wdata;
        end
    end

    // State register
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_reg <= '{rd_page: data_space_pkg::PAGE_RESET, wr_page: data_space_pkg::PAGE_RESET, default: '0};
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // Read data steering
    // ****************************************************************
    always_comb begin
        // Unimplemented locations read as zero
        x_word_data = state_reg.x_ram ? x_ram_word_reg : (state_reg.x_sfr ? state_reg.x_data : 16'h0000);
        if (state_reg.x_byte) begin
            x_rd_data = {8'h00, state_reg.x_hi ? x_word_data[15:8] : x_word_data[7:0]};
        end else begin
            x_rd_data = x_word_data;
        end
    end

    // Y path zero when not multiply-accumulate or outside Y
    logic y_ok_reg;
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            y_ok_reg <= 1'b0;
        end else begin
            y_ok_reg <= y_rd_req && multiply_accumulate_class && y_in_ram && !y_ea[0];
        end
    end
    assign y_rd_data = y_ok_reg ? y_ram_word_reg : 16'h0000;

    assign rd_valid = state_reg.valid;
    assign address_error_trap = state_reg.trap;
    assign read_page_register = state_reg.rd_page;
    assign write_page_register = state_reg.wr_page;
    assign rd_ext_addr = {state_reg.rd_page, x_ea};
    assign wr_ext_addr = {state_reg.wr_page, w_ea};

    // ****************************************************************
    // Working register result formatting
    // ****************************************************************
    always_comb begin
        case (reg_op)
            data_space_pkg::REG_OP_BYTE_LOAD: reg_result = {reg_old[15:8], reg_src[7:0]};
            data_space_pkg::REG_OP_SIGN_EXT: reg_result = {{8{reg_src[7]}}, reg_src[7:0]};
            data_space_pkg::REG_OP_CLEAR_UP: reg_result = {8'h00, reg_src[7:0]};
            default: reg_result = reg_src;
        endcase
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_odd_word_write;
        wr_req && !wr_byte && w_ea[0];
    endsequence

    a_trap_on_odd: assert property (@(posedge core_clk) disable iff (reset)
        s_odd_word_write |=> address_error_trap) else $error("odd word write gave no trap");
    a_write_suppressed: assert property (@(posedge core_clk) disable iff (reset)
        s_odd_word_write |-> !w_commit && !sfr_wr) else $error("misaligned write reached storage");
    a_byte_lane_only: assert property (@(posedge core_clk) disable iff (reset)
        (sfr_wr && wr_byte) |-> (sfr_byte_wr == {w_ea[0], !w_ea[0]})) else $error("wrong byte strobe");
    a_outside_zero: assert property (@(posedge core_clk) disable iff (reset)
        (x_rd_req && !x_in_sfr && !x_in_ram) |=> (x_rd_data == 16'h0000)) else $error("outside read not zero");
    a_byte_low_lane: assert property (@(posedge core_clk) disable iff (reset)
        (x_rd_req && x_rd_byte) |=> (x_rd_data[15:8] == 8'h00)) else $error("byte read high lane set");
    a_y_only_mac: assert property (@(posedge core_clk) disable iff (reset)
        !multiply_accumulate_class |=> (y_rd_data == 16'h0000)) else $error("Y read outside class");
    a_page_extend: assert property (@(posedge core_clk) disable iff (reset)
        read_page_we |=> (rd_ext_addr[23:16] == $past(page_wdata))) else $error("read page not applied");
    a_byte_load_keep: assert property (@(posedge core_clk) disable iff (reset)
        (reg_op == data_space_pkg::REG_OP_BYTE_LOAD) |-> (reg_result[15:8] == reg_old[15:8])) else $error("high byte lost");
    a_outside_write: assert property (@(posedge core_clk) disable iff (reset)
        (wr_req && !w_in_ram) |-> !w_commit) else $error("outside write committed");

endmodule

//--- design/data_space_pkg.sv
/*
 * Constants, address map and operation codes of the data-space access unit.
 * Assumes a single core clock and an asynchronous active-high reset.
 */
// What this block does
// - Byte-granular 16-bit effective addresses, 64 KB.
// - Read/write page registers extend address to 16 MB.
// - Implemented 52 KB; outside reads return zero.
// - Low byte even address, high byte odd.
// - Post-increment pointer adds 1 byte, 2 word.
// - Byte read selects byte onto low lane.
// - Shared word decode, per-byte write strobes.
// - Odd word access raises address error trap.
// - Misaligned write suppressed; trap after instruction.
// - Byte load changes only register low byte.
// - Sign-extend and clear-upper-byte operations provided.
// - 0x0000-0x0FFF special registers; unused read zero.
// - Near region reachable by 13-bit direct field.
// - Whole space via 16-bit direct or pointer.
// - Separate address units for reads and writes.
// - Independent X and Y address and data paths.
// - X read bus serves unified reads, prefetch.
// - Y read only for multiply-accumulate class.
// - Modulo in X,Y; bit-reverse only X writes.
// - Writes use combined space; fixed X/Y boundary.
package data_space_pkg;

    // ****************************************************************
    // Address map
    // ****************************************************************
    localparam logic [15:0] SFR_BASE = 16'h0000;   // Special registers start
    localparam logic [15:0] SFR_LAST = 16'h0FFF;   // Special registers end
    localparam logic [15:0] RAM_BASE = 16'h1000;   // RAM start
    localparam logic [15:0] RAM_LAST = 16'hCFFF;   // RAM end, 48 KB
    localparam logic [15:0] NEAR_LAST = 16'h1FFF;  // Near region end
    localparam logic [15:0] Y_BASE_DEF = 16'h9000; // Fixed X/Y boundary
    localparam int NEAR_BITS = 13;                 // Near direct field width
    localparam int PAGE_BITS = 8;                  // Page register width
    localparam logic [7:0] PAGE_RESET = 8'h01;     // Page value after reset

    // ****************************************************************
    // Address source and modifier codes
    // ****************************************************************
    localparam logic [1:0] SRC_NEAR = 2'h0;        // 13-bit direct field
    localparam logic [1:0] SRC_DIRECT = 2'h1;      // 16-bit direct field
    localparam logic [1:0] SRC_POINTER = 2'h2;     // Indirect via pointer

    localparam logic [1:0] MOD_NONE = 2'h0;        // Pointer unchanged
    localparam logic [1:0] MOD_POST_INC = 2'h1;    // Pointer advanced
    localparam logic [1:0] MOD_POST_DEC = 2'h2;    // Pointer moved back

    // Register-result ops
    localparam logic [1:0] REG_OP_BYTE_LOAD = 2'h1;   // Merge low byte
    localparam logic [1:0] REG_OP_SIGN_EXT = 2'h2;    // Sign-extend byte
    localparam logic [1:0] REG_OP_CLEAR_UP = 2'h3;    // Zero-extend byte

endpackage

//--- design/address_generation_unit.sv
/*
 * One address generation unit: forms the effective address and the
 * updated pointer, with modulo wrap and optional bit-reversed carry.
 * Assumes pointer and buffer bounds are supplied by the core.
 */
`timescale 1ns/100ps
module address_generation_unit #(
    parameter bit ALLOW_BIT_REVERSE = 1'b0
) (
    // Request
    input wire logic [1:0] src_sel,
    input wire logic [1:0] mod_sel,
    input wire logic byte_op,
    input wire logic [15:0] direct_addr,
    input wire logic [15:0] pointer_register,
    // Modulo and bit-reverse control
    input wire logic modulo_en,
    input wire logic [15:0] mod_start,
    input wire logic [15:0] mod_end,
    input wire logic bitrev_en,
    input wire logic [15:0] bitrev_pivot,
    // Results
    output logic [15:0] effective_address,
    output logic [15:0] pointer_next
);

    logic [15:0] step;
    logic [15:0] raw_next;
    logic bitrev_active;

    // Bit-reversed add: carry travels from msb toward lsb
    function automatic logic [15:0] rev_add(input logic [15:0] a, input logic [15:0] b);
        logic [15:0] ra;
        logic [15:0] rb;
        logic [15:0] rs;
        ra = {<<{a}};
        rb = {<<{b}};
        rs = ra + rb;
        return {<<{rs}};
    endfunction

    // Address selection and pointer update
    always_comb begin
        bitrev_active = ALLOW_BIT_REVERSE && bitrev_en && !byte_op && (mod_sel == data_space_pkg::MOD_POST_INC);
        step = byte_op ? 16'h0001 : 16'h0002;
        case (src_sel)
            data_space_pkg::SRC_NEAR: effective_address = {3'h0, direct_addr[data_space_pkg::NEAR_BITS-1:0]};
            data_space_pkg::SRC_DIRECT: effective_address = direct_addr;
            default: effective_address = pointer_register;
        endcase
        if (bitrev_active) begin
            effective_address = {effective_address[15:1], 1'b0};
        end
        case (mod_sel)
            data_space_pkg::MOD_POST_INC: raw_next = pointer_register + step;
            data_space_pkg::MOD_POST_DEC: raw_next = pointer_register - step;
            default: raw_next = pointer_register;
        endcase
        pointer_next = raw_next;
        if (bitrev_active) begin
            pointer_next = rev_add(pointer_register, {bitrev_pivot[14:0], 1'b0}) & 16'hFFFE;
        end else if (modulo_en && (mod_sel == data_space_pkg::MOD_POST_INC) && (raw_next > mod_end)) begin
            pointer_next = raw_next - (mod_end - mod_start + 16'h0001);
        end else if (modulo_en && (mod_sel == data_space_pkg::MOD_POST_DEC) && (raw_next < mod_start)) begin
            pointer_next = raw_next + (mod_end - mod_start + 16'h0001);
        end
    end

endmodule

//--- bench/sfr_model.sv
/*
 * Far-side special register block: sixteen words at 0x0800..0x081E.
 * Assumes the access unit's combinational sfr port on core_clk.
 */
`timescale 1ns/100ps
module sfr_model (
    // Clock
    input wire logic core_clk,
    // Requests from the access unit
    input wire logic [15:0] sfr_addr,
    input wire logic sfr_rd,
    input wire logic sfr_wr,
    input wire logic [1:0] sfr_byte_wr,
    input wire logic [15:0] sfr_wdata,
    // Answer
    output logic [15:0] sfr_rdata,
    output logic sfr_hit
);
    logic [15:0] regs [16] = '{default: 16'h0000}; // Register cells
    logic [15:0] last_q = 16'h0000; // Last value answered
    wire logic in_range = sfr_addr[15:5] == 11'h040; // Block decode
    // Answer only selected reads; stale lines show inverted data
    always_comb begin
        sfr_hit = sfr_rd && in_range;
        sfr_rdata = sfr_hit ? regs[sfr_addr[4:1]] : ~last_q;
    end
    // Per-lane writes
    always @(posedge core_clk) begin
        if (sfr_hit) last_q <= regs[sfr_addr[4:1]];
        if (sfr_wr && in_range && sfr_byte_wr[0]) regs[sfr_addr[4:1]][7:0] <= sfr_wdata[7:0];
        if (sfr_wr && in_range && sfr_byte_wr[1]) regs[sfr_addr[4:1]][15:8] <= sfr_wdata[15:8];
    end
endmodule

//--- bench/data_space_access_unit_bench.sv
/*
 * Self-checking bench of the data-space access unit.
 * Assumes the sfr_model partner and a 100 ns core clock.
 */
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
    $display("mismatch %s expected %h seen %h", n, e, g); end end
module data_space_access_unit_bench;
    // ****************************************************************
    // Stimulus and results
    // ****************************************************************
    logic core_clk = 1'b0, reset = 1'b1, x_rd_req = 1'b0, x_rd_byte = 1'b0, y_rd_req = 1'b0;
    logic multiply_accumulate_class = 1'b0, wr_req = 1'b0, wr_byte = 1'b0, modulo_en = 1'b0;
    logic bitrev_en = 1'b0, read_page_we = 1'b0, write_page_we = 1'b0, sfr_hit, sfr_rd, sfr_wr;
    logic [1:0] x_rd_src = 2'h0, x_rd_mod = 2'h0, y_rd_mod = 2'h0, wr_src = 2'h0, wr_mod = 2'h0;
    logic [1:0] reg_op = 2'h0, sfr_byte_wr;
    logic [15:0] x_rd_direct = 16'h0000, x_rd_pointer = 16'h0000, y_rd_pointer = 16'h0000;
    logic [15:0] wr_direct = 16'h0000, wr_pointer = 16'h0000, wr_data = 16'h0000, reg_old = 16'h0000;
    logic [15:0] mod_start = 16'h0000, mod_end = 16'h0000, bitrev_pivot = 16'h0000, reg_src = 16'h0000;
    logic [15:0] sfr_rdata, sfr_addr, sfr_wdata, x_rd_data, y_rd_data, x_rd_pointer_next;
    logic [15:0] y_rd_pointer_next, wr_pointer_next, reg_result, e;
    logic [23:0] rd_ext_addr, wr_ext_addr;
    logic [7:0] page_wdata = 8'h00, read_page_register, write_page_register;
    logic [7:0] rpage = 8'h01, wpage = 8'h01; // Expected page values
    logic rd_valid, address_error_trap;
    logic [15:0] mem [int]; // Expected storage, by word address
    int num_errors = 0, checks_done = 0;
    // Free-running core clock
    always #50 core_clk = ~core_clk;
    data_space_access_unit #(.RAM_WORDS(32'h0000_4100)) dut_u (.core_clk, .reset, .x_rd_req, .x_rd_byte,
        .x_rd_src, .x_rd_mod, .x_rd_direct, .x_rd_pointer, .y_rd_req, .multiply_accumulate_class,
        .y_rd_mod, .y_rd_pointer, .wr_req, .wr_byte, .wr_src, .wr_mod, .wr_direct, .wr_pointer,
        .wr_data, .modulo_en, .mod_start, .mod_end, .bitrev_en, .bitrev_pivot, .read_page_we,
        .write_page_we, .page_wdata, .reg_op, .reg_old, .reg_src, .sfr_rdata, .sfr_hit, .sfr_addr,
        .sfr_rd, .sfr_wr, .sfr_byte_wr, .sfr_wdata, .x_rd_data, .y_rd_data, .rd_valid,
        .x_rd_pointer_next, .y_rd_pointer_next, .wr_pointer_next, .rd_ext_addr, .wr_ext_addr,
        .read_page_register, .write_page_register, .reg_result, .address_error_trap);
    sfr_model sfr_u (.core_clk, .sfr_addr, .sfr_rd, .sfr_wr, .sfr_byte_wr, .sfr_wdata, .sfr_rdata, .sfr_hit);
    // ****************************************************************
    // Expectation helpers and bus tasks
    // ****************************************************************
    // Stored word, zero where nothing lives
    function automatic logic [15:0] expw(logic [15:0] a);
        return mem.exists(a[15:1]) ? mem[a[15:1]] : 16'h0000;
    endfunction
    // Places that keep written data
    function automatic bit kept(logic [15:0] a);
        return (a >= 16'h1000 && a < 16'h9200) || a[15:5] == 11'h040;
    endfunction
    // One write through a post-incremented pointer
    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic b);
        logic [15:0] w;
        w = expw(a);
        w = b ? (a[0] ? {d[7:0], w[7:0]} : {w[15:8], d[7:0]}) : d;
        @(posedge core_clk);
        {wr_req, wr_byte, wr_src, wr_mod} <= {1'b1, b, data_space_pkg::SRC_POINTER, data_space_pkg::MOD_POST_INC};
        {wr_pointer, wr_direct, wr_data} <= {a, a, d};
        #1 `CHK("wr_pointer_next", a + (b ? 16'h0001 : 16'h0002), wr_pointer_next)
        `CHK("wr_ext_addr", {wpage, a}, wr_ext_addr)
        @(posedge core_clk);
        wr_req <= 1'b0;
        #1 `CHK("write trap", !b && a[0], address_error_trap)
        if (!(!b && a[0]) && kept(a)) mem[a[15:1]] = w;
    endtask
    // X read, optionally paired with a concurrent Y read
    task automatic rd(input logic [15:0] a, input logic b, input logic [1:0] s, input logic [15:0] ya, input logic y);
        @(posedge core_clk);
        {x_rd_req, x_rd_byte, x_rd_src, x_rd_mod} <= {1'b1, b, s, data_space_pkg::MOD_POST_DEC};
        {x_rd_direct, x_rd_pointer, y_rd_pointer} <= {a, a, ya};
        {y_rd_req, multiply_accumulate_class, y_rd_mod} <= {y, y, data_space_pkg::MOD_POST_INC};
        #1 `CHK("x_rd_pointer_next", a - (b ? 16'h0001 : 16'h0002), x_rd_pointer_next)
        `CHK("rd_ext_addr", {rpage, a}, rd_ext_addr)
        if (y) `CHK("y_rd_pointer_next", ya + 16'h0002, y_rd_pointer_next)
        @(posedge core_clk);
        {x_rd_req, y_rd_req} <= 2'b00;
        e = (!b && a[0]) ? 16'h0000 : expw(a);
        #1 `CHK("rd_valid", 1'b1, rd_valid)
        `CHK("read trap", !b && a[0], address_error_trap)
        if (b) `CHK("byte data", {8'h00, a[0] ? e[15:8] : e[7:0]}, x_rd_data)
        else `CHK("x_rd_data", e, x_rd_data)
        if (y) `CHK("y_rd_data", expw(ya), y_rd_data)
    endtask
    // Verdict and end of run
    task automatic end_of_test();
        if (num_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        logic [15:0] a;
        void'($urandom(32'h5d36_fad6));
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        #1 `CHK("read page", data_space_pkg::PAGE_RESET, read_page_register)
        // Clear the words the random mix touches, so no lane starts unknown
        for (int i = 0; i < 32; i += 2) begin
            wr(16'h1000 + 16'(i), 16'h0000, 1'b0);
            wr(16'h9000 + 16'(i), 16'h0000, 1'b0);
        end
        // Corners: word and byte lanes, misaligned, unused and near
        wr(16'h1002, 16'ha55a, 1'b0);
        wr(16'h1003, 16'h00c3, 1'b1);
        wr(16'h1004, 16'h1234, 1'b1);
        wr(16'h1005, 16'h7777, 1'b0);
        rd(16'h1002, 1'b0, data_space_pkg::SRC_NEAR, 16'h9000, 1'b0);
        rd(16'h1003, 1'b1, data_space_pkg::SRC_POINTER, 16'h9000, 1'b0);
        rd(16'h0f00, 1'b0, data_space_pkg::SRC_DIRECT, 16'h9000, 1'b0);
        // Random mix over RAM, Y region, special and unimplemented space
        for (int i = 0; i < 120; i++) begin
            a = ($urandom % 4 == 0) ? 16'h0800 : 16'h1000;
            a = ($urandom % 3 == 0) ? 16'h9000 : (($urandom % 4 == 0) ? 16'he000 : a);
            a = a + 16'($urandom % 32);
            if ($urandom % 2) wr(a, 16'($urandom), 1'($urandom));
            else rd(a, 1'($urandom), data_space_pkg::SRC_DIRECT, 16'h9000 + 16'($urandom % 16) * 2, 1'($urandom));
        end
        // Page loads change the extended addresses
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            {read_page_we, write_page_we, page_wdata} <= {1'b1, i[0], 8'($urandom)};
            @(posedge core_clk);
            {read_page_we, write_page_we} <= 2'b00;
            rpage = page_wdata;
            wpage = i[0] ? page_wdata : wpage;
            #1 `CHK("read_page_register", rpage, read_page_register)
            `CHK("write_page_register", wpage, write_page_register)
            wr(16'h1010, 16'($urandom), 1'b0);
            rd(16'h1010, 1'b0, data_space_pkg::SRC_DIRECT, 16'h9002, 1'b1);
        end
        // Register result formatting for every operation code
        for (int op = 0; op < 4; op++) begin
            @(posedge core_clk);
            {reg_op, reg_old, reg_src} <= {2'(op), 16'($urandom), 16'($urandom)};
            #1 e = (op == 1) ? {reg_old[15:8], reg_src[7:0]} : {{8{reg_src[7]}}, reg_src[7:0]};
            e = (op == 3) ? {8'h00, reg_src[7:0]} : ((op == 0) ? reg_src : e);
            `CHK("reg_result", e, reg_result)
        end
        end_of_test();
    end
    // Hang guard
    initial begin
        #(100 * 90000);
        num_errors++;
        end_of_test();
    end
endmodule
